// >>> src/plrfl_pkg.sv
// package: constants and types for the power loss restart and frequency limiter
package plrfl_pkg;
   // clock rate and derived cycle counts
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned RUN_WAIT_MS = 2000;
   localparam longint unsigned RUN_WAIT_CYC_DEF =
      longint'(CLK_HZ) / 1000 * RUN_WAIT_MS;
   // restart delay defaults, in milliseconds
   localparam int unsigned DELAY_SMALL_MS = 500;
   localparam int unsigned DELAY_LARGE_MS = 1000;
   // one tick per millisecond drives the delay counter and fall rate
   localparam int unsigned TICK_CYC_DEF = CLK_HZ / 1000;
   localparam int unsigned CHARGE_CYC_DEF = 16;
   // frequencies are in 0.01 Hz units; rates in 0.01 Hz/s units
   localparam logic [15:0] FREQ_MAX = 16'h9C40;
   localparam logic [15:0] RATE_MAX = 16'h2710;
   localparam logic [15:0] RATE_PI_CODE = 16'h03E7;
   localparam logic [15:0] RATE_NORMAL = 16'h0000;
   // restart mode codes
   localparam logic [2:0] MODE_TRIP_NOW = 3'h0;
   localparam logic [2:0] MODE_TRIP_AFTER = 3'h1;
   localparam logic [2:0] MODE_DECEL_TRIP = 3'h2;
   localparam logic [2:0] MODE_PRELOSS = 3'h4;
   localparam logic [2:0] MODE_START_FREQ = 3'h5;
   // run command source codes with fixed direction
   localparam logic [1:0] SRC_FIXED_FWD = 2'h2;
   localparam logic [1:0] SRC_FIXED_REV = 2'h3;
   localparam logic [15:0] ZERO_FREQ = 16'h0000;

   typedef enum {
      PLRFL_ST_NORMAL, PLRFL_ST_LOST, PLRFL_ST_CHARGE, PLRFL_ST_WAIT,
      PLRFL_ST_MATCH, PLRFL_ST_DECEL, PLRFL_ST_TRIP
   } plrfl_state_t;
endpackage

// >>> src/plrfl_top.sv
// file: power loss restart sequencer with output frequency limiter
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - flag supply loss only when link voltage under threshold while running
// - on loss enter restart; on return charge first, then ready to run
// - when ready, wait two seconds for run; run starts restart by mode
// - no run within window leaves restart; later start uses start freq
// - terminal direction waits for run; fixed direction restarts at ready
// - coast command during loss ends restart, normal start follows
// - restart at pre-loss frequency, current limit lowers, then reaccelerate
// - no restart before restart delay from the loss has expired
// - restart delay default short for small ratings, long for largest
// - under overcurrent limit during restart lower frequency at fall rate
// - fall rate zero normal decel, 0.01..100 Hz/s rate, 999 fixed PI
// - decel-trip mode starts decel stop below continuous run level
// - undervoltage during decel stop turns output off and coasts
// - clamp output frequency between high and low limits, 0..400 Hz
// - below low limit, mode zero holds limit, mode one decelerates
// - mode zero raises undervoltage alarm and cuts output at once
// - mode four saves loss frequency, restarts there if run present
// - mode five restarts at starting frequency on run after return
module plrfl_top #(
   parameter longint unsigned RUN_WAIT_CYC = plrfl_pkg::RUN_WAIT_CYC_DEF,
   parameter int unsigned TICK_CYC = plrfl_pkg::TICK_CYC_DEF,
   parameter bit LARGE_RATING = 1'b0
) (
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // supply monitor
   input wire logic UNDERVOLT_I,
   input wire logic BELOW_CONT_LEVEL_I,
   input wire logic SUPPLY_OK_I,
   input wire logic [15:0] DC_LINK_ERR_I,
   // commands
   input wire logic FORWARD_RUN_TERMINAL_I,
   input wire logic REVERSE_RUN_TERMINAL_I,
   input wire logic KEYPAD_RUN_I,
   input wire logic COAST_STOP_COMMAND_I,
   input wire logic CURRENT_LIMIT_ACTIVE_I,
   // frequency generator
   input wire logic [15:0] FREQ_REF_I,
   input wire logic [15:0] DECEL_STEP_I,
   output logic [15:0] FREQ_OUT_O,
   output logic OUTPUT_ON_O,
   output logic UNDERVOLT_ALARM_O,
   output logic PI_LIMIT_SEL_O,
   output logic RESTART_ACTIVE_O
);
   import plrfl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // register offsets and state
   localparam logic [7:0] A_MODE = 8'h00;
   localparam logic [7:0] A_DELAY = 8'h04;
   localparam logic [7:0] A_RATE = 8'h08;
   localparam logic [7:0] A_GAINS = 8'h0C;
   localparam logic [7:0] A_LIMITS = 8'h10;
   localparam logic [7:0] A_START = 8'h14;
   localparam logic [7:0] A_STATUS = 8'h18;
   localparam int unsigned MS_PER_S = 1000;

   typedef struct packed {
      plrfl_state_t st;
      logic [2:0] mode;
      logic [1:0] src;
      logic low_act;
      logic oc_en;
      logic [15:0] delay_ms;
      logic [15:0] rate;
      logic [15:0] kp;
      logic [15:0] ki;
      logic [15:0] hi;
      logic [15:0] lo;
      logic [15:0] start_f;
      logic [15:0] freq;
      logic [15:0] saved;
      logic [31:0] integ;
      logic [31:0] wait_cnt;
      logic [31:0] tick_cnt;
      logic [15:0] ms_cnt;
      logic [15:0] acc;
      logic alarm;
      logic out_on;
      logic [31:0] rdata;
      logic loss_flag;
   } plrfl_regs_t;

   plrfl_regs_t s_r, s_nxt;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [15:0] sat_sub(input logic [15:0] a,
                                           input logic [15:0] b);
      sat_sub = (a > b) ? 16'(a - b) : ZERO_FREQ;
   endfunction

   // high limit wins over an inverted low limit
   function automatic logic [15:0] clamp(input logic [15:0] f,
                                         input logic [15:0] h,
                                         input logic [15:0] l);
      logic [15:0] r;
      r = f;
      if (r < l) begin
         r = l;
      end
      if (r > h) begin
         r = h;
      end
      clamp = r;
   endfunction

   logic run_cmd;
   logic fixed_dir;
   logic tick;
   logic delay_done;
   logic setup_wr;
   assign run_cmd = FORWARD_RUN_TERMINAL_I | REVERSE_RUN_TERMINAL_I |
                    KEYPAD_RUN_I;
   assign fixed_dir = (s_r.src == SRC_FIXED_FWD) ||
                      (s_r.src == SRC_FIXED_REV);
   assign tick = (s_r.tick_cnt == 32'(TICK_CYC - 1));
   assign delay_done = (s_r.ms_cnt >= s_r.delay_ms);
   assign setup_wr = PSEL_I & PENABLE_I & PWRITE_I;

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic [15:0] step;
      logic [31:0] pi;
      logic [31:0] sum;
      step = ZERO_FREQ;
      pi = 32'h0000_0000;
      sum = 32'(s_r.acc) + 32'(s_r.rate);
      s_nxt = s_r;
      s_nxt.tick_cnt = tick ? 32'h0000_0000 : 32'(s_r.tick_cnt + 1);
      if (s_r.st != PLRFL_ST_NORMAL && tick && !delay_done) begin
         s_nxt.ms_cnt = 16'(s_r.ms_cnt + 1);
      end
      // fall-rate decode: hz/s spread over millisecond ticks, remainder kept
      if (s_r.rate == RATE_NORMAL || s_r.rate == RATE_PI_CODE ||
          s_r.rate > RATE_MAX) begin
         step = DECEL_STEP_I;
      end else begin
         step = 16'(sum / MS_PER_S);
      end
      unique case (s_r.st)
         PLRFL_ST_NORMAL: begin
            s_nxt.out_on = run_cmd & ~COAST_STOP_COMMAND_I;
            if (s_nxt.out_on) begin
               s_nxt.freq = clamp(s_r.out_on ? FREQ_REF_I : s_r.start_f,
                                  s_r.hi, s_r.lo);
               // low limit action: decelerate instead of holding
               if (FREQ_REF_I < s_r.lo && s_r.low_act) begin
                  s_nxt.freq = sat_sub(s_r.freq, DECEL_STEP_I);
                  s_nxt.out_on = (s_r.freq != ZERO_FREQ);
               end
            end else begin
               s_nxt.freq = s_r.start_f;
            end
            if (s_r.out_on && s_r.mode == MODE_DECEL_TRIP &&
                BELOW_CONT_LEVEL_I) begin
               s_nxt.st = PLRFL_ST_DECEL;
               s_nxt.integ = 32'h0000_0000;
            end else if (s_r.out_on && UNDERVOLT_I) begin
               s_nxt.loss_flag = 1'b1;
               s_nxt.out_on = 1'b0;
               s_nxt.ms_cnt = 16'h0000;
               s_nxt.saved = s_r.freq;
               if (s_r.mode == MODE_TRIP_NOW) begin
                  s_nxt.alarm = 1'b1;
                  s_nxt.st = PLRFL_ST_TRIP;
               end else begin
                  s_nxt.st = PLRFL_ST_LOST;
               end
            end
         end
         PLRFL_ST_LOST: begin
            s_nxt.out_on = 1'b0;
            s_nxt.wait_cnt = 32'h0000_0000;
            if (COAST_STOP_COMMAND_I) begin
               s_nxt.st = PLRFL_ST_NORMAL;
               s_nxt.freq = s_r.start_f;
            end else if (SUPPLY_OK_I) begin
               if (s_r.mode == MODE_TRIP_AFTER) begin
                  s_nxt.alarm = 1'b1;
                  s_nxt.st = PLRFL_ST_TRIP;
               end else begin
                  s_nxt.st = PLRFL_ST_CHARGE;
               end
            end
         end
         PLRFL_ST_CHARGE: begin
            s_nxt.wait_cnt = 32'(s_r.wait_cnt + 1);
            if (COAST_STOP_COMMAND_I) begin
               s_nxt.st = PLRFL_ST_NORMAL;
               s_nxt.freq = s_r.start_f;
            end else if (s_r.wait_cnt == 32'(CHARGE_CYC_DEF - 1)) begin
               s_nxt.st = PLRFL_ST_WAIT;
               s_nxt.wait_cnt = 32'h0000_0000;
            end
         end
         PLRFL_ST_WAIT: begin
            s_nxt.wait_cnt = 32'(s_r.wait_cnt + 1);
            if (COAST_STOP_COMMAND_I) begin
               s_nxt.st = PLRFL_ST_NORMAL;
               s_nxt.freq = s_r.start_f;
            end else if ((run_cmd || fixed_dir) && delay_done) begin
               s_nxt.out_on = 1'b1;
               s_nxt.acc = 16'h0000;
               if (s_r.mode == MODE_PRELOSS) begin
                  s_nxt.freq = s_r.saved;
                  s_nxt.st = PLRFL_ST_MATCH;
               end else begin
                  s_nxt.freq = s_r.start_f;
                  s_nxt.st = PLRFL_ST_NORMAL;
               end
            end else if (s_r.wait_cnt >= 32'(RUN_WAIT_CYC - 1)) begin
               s_nxt.st = PLRFL_ST_NORMAL;
               s_nxt.freq = s_r.start_f;
            end
         end
         PLRFL_ST_MATCH: begin
            if (COAST_STOP_COMMAND_I || !run_cmd && !fixed_dir) begin
               s_nxt.st = PLRFL_ST_NORMAL;
               s_nxt.out_on = 1'b0;
            end else if (CURRENT_LIMIT_ACTIVE_I) begin
               if (tick || s_r.rate == RATE_NORMAL ||
                   s_r.rate == RATE_PI_CODE) begin
                  s_nxt.freq = sat_sub(s_r.freq, step);
                  s_nxt.acc = 16'(sum % MS_PER_S);
               end
            end else begin
               s_nxt.st = PLRFL_ST_NORMAL; // reaccelerate to reference
            end
         end
         PLRFL_ST_DECEL: begin
            // pi on link voltage error sets the decrement per cycle
            s_nxt.integ = 32'(s_r.integ + 32'(s_r.ki) * 32'(DC_LINK_ERR_I));
            pi = 32'(32'(s_r.kp) * 32'(DC_LINK_ERR_I)) + s_r.integ;
            s_nxt.freq = sat_sub(s_r.freq, pi[31:16]);
            if (UNDERVOLT_I) begin
               s_nxt.out_on = 1'b0;
               s_nxt.st = PLRFL_ST_TRIP; // held off so a held run waits
            end else if (s_r.freq == ZERO_FREQ) begin
               s_nxt.out_on = 1'b0;
               s_nxt.alarm = 1'b1;
               s_nxt.st = PLRFL_ST_TRIP;
            end
         end
         PLRFL_ST_TRIP: begin
            s_nxt.out_on = 1'b0;
            if (COAST_STOP_COMMAND_I) begin
               s_nxt.st = PLRFL_ST_NORMAL;
            end
         end
      endcase
      // apb writes in access phase
      if (setup_wr) begin
         unique case (PADDR_I)
            A_MODE: begin
               s_nxt.mode = PWDATA_I[2:0];
               s_nxt.src = PWDATA_I[5:4];
               s_nxt.low_act = PWDATA_I[8];
               s_nxt.oc_en = PWDATA_I[12];
            end
            A_DELAY: s_nxt.delay_ms = PWDATA_I[15:0];
            A_RATE: s_nxt.rate = PWDATA_I[15:0];
            A_GAINS: begin
               s_nxt.kp = PWDATA_I[15:0];
               s_nxt.ki = PWDATA_I[31:16];
            end
            A_LIMITS: begin
               s_nxt.hi = (PWDATA_I[15:0] > FREQ_MAX) ? FREQ_MAX :
                          PWDATA_I[15:0];
               s_nxt.lo = (PWDATA_I[31:16] > FREQ_MAX) ? FREQ_MAX :
                          PWDATA_I[31:16];
            end
            A_START: s_nxt.start_f = PWDATA_I[15:0];
            A_STATUS: begin
               // write one clears; a new loss in the same cycle wins
               if (PWDATA_I[0] && !(s_nxt.loss_flag && !s_r.loss_flag)) begin
                  s_nxt.loss_flag = 1'b0;
               end
               if (PWDATA_I[1] && !(s_nxt.alarm && !s_r.alarm)) begin
                  s_nxt.alarm = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // read data captured at setup
      unique case (PADDR_I)
         A_MODE: s_nxt.rdata = {19'h0_0000, s_r.oc_en, 3'h0, s_r.low_act,
                                2'h0, s_r.src, 1'h0, s_r.mode};
         A_DELAY: s_nxt.rdata = {16'h0000, s_r.delay_ms};
         A_RATE: s_nxt.rdata = {16'h0000, s_r.rate};
         A_GAINS: s_nxt.rdata = {s_r.ki, s_r.kp};
         A_LIMITS: s_nxt.rdata = {s_r.lo, s_r.hi};
         A_START: s_nxt.rdata = {16'h0000, s_r.start_f};
         A_STATUS: s_nxt.rdata = {s_r.freq, 8'h00, 4'(s_r.st),
                                  (s_r.lo > s_r.hi), s_r.out_on,
                                  s_r.alarm, s_r.loss_flag};
         default: s_nxt.rdata = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s_r <= '0;
         s_r.st <= PLRFL_ST_NORMAL;
         s_r.delay_ms <= LARGE_RATING ? 16'(DELAY_LARGE_MS) :
                         16'(DELAY_SMALL_MS);
         s_r.hi <= FREQ_MAX;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign PREADY_O = 1'b1; // zero wait states
   assign PSLVERR_O = PSEL_I & PENABLE_I & (PADDR_I > A_STATUS |
                      PADDR_I[1:0] != 2'b00);
   assign PRDATA_O = s_r.rdata;
   assign FREQ_OUT_O = s_r.out_on ? s_r.freq : ZERO_FREQ;
   assign OUTPUT_ON_O = s_r.out_on;
   assign UNDERVOLT_ALARM_O = s_r.alarm;
   assign PI_LIMIT_SEL_O = (s_r.rate == RATE_PI_CODE);
   assign RESTART_ACTIVE_O = s_r.st inside {PLRFL_ST_LOST, PLRFL_ST_CHARGE,
                                            PLRFL_ST_WAIT, PLRFL_ST_MATCH};
endmodule
`default_nettype wire

// >>> verification/plrfl_motor.sv
// partner: idling motor with overcurrent limiter
`timescale 1ns/10ps
`default_nettype none
module plrfl_motor (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // drive output
   input wire logic [15:0] freq_i,
   input wire logic on_i,
   // limiter and decel step
   output logic cur_lim_o,
   output logic [15:0] dstep_o
);
   logic [15:0] speed_r;
   assign dstep_o = 16'h0004;
   // limiter trips while the drive leads the rotor by over 1 hz
   assign cur_lim_o = on_i && (freq_i > speed_r + 16'h0064);
   // rotor creeps up under limit so a plain start cannot lock up
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         speed_r <= 16'h0000;
      end else if (on_i && !cur_lim_o) begin
         speed_r <= freq_i;
      end else if (on_i) begin
         speed_r <= speed_r + 16'h0002;
      end else if (speed_r > 16'h0003) begin
         speed_r <= speed_r - 16'h0004;
      end
   end
endmodule
`default_nettype wire

// >>> verification/plrfl_props.sv
// checker: port assertions for the restart sequencer
`timescale 1ns/10ps
`default_nettype none
module plrfl_props (
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   // apb
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // drive side
   input wire logic UNDERVOLT_I,
   input wire logic SUPPLY_OK_I,
   input wire logic COAST_STOP_COMMAND_I,
   input wire logic [15:0] FREQ_OUT_O,
   input wire logic OUTPUT_ON_O,
   input wire logic UNDERVOLT_ALARM_O,
   input wire logic PI_LIMIT_SEL_O,
   input wire logic RESTART_ACTIVE_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   ////////////////////////////////////////////////////////////////////////
   // access phase and decoded write helpers
   wire logic acc = PSEL_I && PENABLE_I;
   wire logic pi_code = PWDATA_I[15:0] == 16'h03E7;
   wire logic clr = acc && PWRITE_I && PADDR_I == 8'h18 && PWDATA_I[1];
   a_bus_ready: assert property (PSEL_I |-> PREADY_O)
      else $error("pready low in a transfer");
   a_bus_err: assert property (acc && PADDR_I > 8'h18 |-> PSLVERR_O)
      else $error("unmapped access not refused");
   a_bus_ok: assert property (acc && PADDR_I <= 8'h18
      && PADDR_I[1:0] == 2'h0 |-> !PSLVERR_O)
      else $error("mapped access refused");
   a_loss_cut: assert property (OUTPUT_ON_O && UNDERVOLT_I |=> !OUTPUT_ON_O)
      else $error("output kept on under undervoltage");
   a_off_zero: assert property (!OUTPUT_ON_O |-> FREQ_OUT_O == 16'h0000)
      else $error("frequency shown while output off");
   a_freq_cap: assert property (FREQ_OUT_O <= 16'h9C40)
      else $error("frequency above range");
   a_charge_hold: assert property ($rose(SUPPLY_OK_I) && RESTART_ACTIVE_O
      |-> !OUTPUT_ON_O [*8])
      else $error("restart before charging");
   a_coast_exit: assert property (RESTART_ACTIVE_O && COAST_STOP_COMMAND_I
      |-> ##[1:3] !RESTART_ACTIVE_O)
      else $error("coast did not end restart");
   a_pi_code: assert property (acc && PWRITE_I && PADDR_I == 8'h08
      |=> PI_LIMIT_SEL_O == $past(pi_code))
      else $error("pi select wrong for fall rate");
   a_alarm_stay: assert property (UNDERVOLT_ALARM_O && !clr
      |=> UNDERVOLT_ALARM_O)
      else $error("alarm dropped without clear");
   // main scenarios reached
   c_restart: cover property ($fell(RESTART_ACTIVE_O) && OUTPUT_ON_O);
   c_alarm: cover property ($rose(UNDERVOLT_ALARM_O));
   c_pi: cover property ($rose(PI_LIMIT_SEL_O));
endmodule
bind plrfl_top plrfl_props u_props (.CLK_SYS_I, .RST_N_I, .PSEL_I,
   .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PREADY_O, .PSLVERR_O,
   .UNDERVOLT_I, .SUPPLY_OK_I, .COAST_STOP_COMMAND_I, .FREQ_OUT_O,
   .OUTPUT_ON_O, .UNDERVOLT_ALARM_O, .PI_LIMIT_SEL_O, .RESTART_ACTIVE_O);
`default_nettype wire

// >>> verification/plrfl_top_tb.sv
// testbench: scenario tasks for the restart sequencer
`timescale 1ns/10ps
`default_nettype none
module plrfl_top_tb;
   import plrfl_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic uv = 1'b0, sok = 1'b1, forward_run_terminal = 1'b0, kpd = 1'b0, coast = 1'b0;
   logic [15:0] fref = 16'h0000, lerr = 16'h0000;
   logic bcl = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, on, alarm, pisel, ract, curlim, e;
   logic [15:0] fout, dstep, f;
   int fails = 0, n_checks = 0, k;
   always #2 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   // short counts keep the run brief
   plrfl_top #(.RUN_WAIT_CYC(200), .TICK_CYC(4), .LARGE_RATING(1'b0)) u_dut (
      .CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .UNDERVOLT_I(uv),
      .BELOW_CONT_LEVEL_I(bcl), .SUPPLY_OK_I(sok),
      .DC_LINK_ERR_I(lerr), .FORWARD_RUN_TERMINAL_I(forward_run_terminal),
      .REVERSE_RUN_TERMINAL_I(1'b0), .KEYPAD_RUN_I(kpd),
      .COAST_STOP_COMMAND_I(coast), .CURRENT_LIMIT_ACTIVE_I(curlim),
      .FREQ_REF_I(fref), .DECEL_STEP_I(dstep), .FREQ_OUT_O(fout),
      .OUTPUT_ON_O(on), .UNDERVOLT_ALARM_O(alarm), .PI_LIMIT_SEL_O(pisel),
      .RESTART_ACTIVE_O(ract));
   plrfl_motor u_motor (.clk_i(clk), .rst_n_i(rst_n), .freq_i(fout),
      .on_i(on), .cur_lim_o(curlim), .dstep_o(dstep));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      n_checks++;
      if (got !== ex) begin
         $display("wrong value %s: expected %h, seen %h", nm, ex, got);
         fails++;
      end
   endtask
   // one transfer, held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // bounded waits on output state and frequency
   task automatic won(input logic v);
      for (k = 0; k < 3000 && on !== v; k++) @(posedge clk);
      f = fout;
   endtask
   task automatic wf(input logic [15:0] v, input bit lt);
      for (k = 0; k < 3000 && (lt ? !(fout < v) : fout !== v); k++)
         @(posedge clk);
   endtask
   // supply loss of four cycles, run commands set as asked
   task automatic loss(input logic run);
      @(posedge clk);
      uv <= 1'b1;
      sok <= 1'b0;
      forward_run_terminal <= run;
      kpd <= run;
      repeat (4) @(posedge clk);
      uv <= 1'b0;
      sok <= 1'b1;
   endtask
   task automatic final_report;
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      apb(0, 8'h04, 0);
      chk("delay reset", 32'h0000_01F4, rd);
      apb(0, 8'h10, 0);
      chk("limit reset", {16'h0000, FREQ_MAX}, rd);
      apb(0, 8'h1C, 0);
      chk("unmapped err", 1, e);
      chk("unmapped data", 0, rd);
      apb(1, 8'h08, {16'h0000, RATE_PI_CODE});
      @(posedge clk);
      chk("pi select", 1, pisel);
      apb(1, 8'h08, {16'h0000, RATE_MAX});
      @(posedge clk);
      chk("rate select", 0, pisel);
      @(posedge clk);
      uv <= 1'b1;
      repeat (3) @(posedge clk);
      uv <= 1'b0;
      apb(0, 8'h18, 0);
      chk("idle dip flag", 0, rd[0]);
      $display("done: registers");
   endtask
   task automatic t_limit;
      apb(1, 8'h10, 32'h00C8_03E8);
      forward_run_terminal <= 1'b1;
      fref <= 16'h1388;
      wf(16'h03E8, 0);
      chk("high clamp", 16'h03E8, fout);
      fref <= 16'h0032;
      wf(16'h00C8, 0);
      chk("low hold", 16'h00C8, fout);
      apb(1, 8'h10, 32'h0BB8_03E8);
      wf(16'h03E8, 0);
      chk("low above high", 16'h03E8, fout);
      apb(0, 8'h18, 0);
      chk("invalid flag", 1, rd[3]);
      apb(1, 8'h10, 32'h00C8_9C40);
      apb(1, 8'h00, 32'h0000_0100);
      won(0);
      chk("low stop", 0, on);
      apb(1, 8'h10, {16'h0000, FREQ_MAX});
      fref <= 16'h0BB8;
      $display("done: limits");
   endtask
   task automatic t_m4;
      apb(1, 8'h00, 32'h0000_1004);
      apb(1, 8'h04, 32'h0000_000A);
      wf(16'h0BB8, 0);
      loss(1);
      chk("restart state", 1, ract);
      won(1);
      chk("delay kept", 1, k > 30);
      chk("resume freq", 16'h0BB8, f);
      wf(16'h0BB8, 1);
      chk("falls", 1, fout < 16'h0BB8);
      wf(16'h0BB8, 0);
      chk("regains", 16'h0BB8, fout);
      $display("done: pre-loss restart");
   endtask
   task automatic t_m5;
      apb(1, 8'h00, {29'h0, MODE_START_FREQ});
      apb(1, 8'h14, 32'h0000_01F4);
      loss(1);
      won(1);
      chk("start freq", 16'h01F4, f);
      loss(0);
      for (k = 0; k < 2000 && ract !== 1'b0; k++) @(posedge clk);
      chk("window length", 1, k > 200);
      chk("window end", 0, ract);
      chk("no run off", 0, on);
      forward_run_terminal <= 1'b1;
      won(1);
      chk("ordinary start", 16'h01F4, f);
      $display("done: start freq and window");
   endtask
   task automatic t_fix;
      apb(1, 8'h00, 32'h0000_1024);
      forward_run_terminal <= 1'b0;
      kpd <= 1'b1;
      wf(16'h0BB8, 0);
      loss(0);
      won(1);
      chk("fixed dir restart", 1, on);
      apb(1, 8'h00, 32'h0000_1004);
      forward_run_terminal <= 1'b1;
      wf(16'h0BB8, 0);
      loss(1);
      coast <= 1'b1;
      repeat (4) @(posedge clk);
      chk("coast exit", 0, ract);
      coast <= 1'b0;
      won(1);
      chk("coast then start", 16'h01F4, f);
      $display("done: fixed and coast");
   endtask
   task automatic t_m2;
      apb(1, 8'h0C, 32'h0100_0100);
      apb(1, 8'h00, {29'h0, MODE_DECEL_TRIP});
      wf(16'h0BB8, 0);
      lerr <= 16'h0100;
      bcl <= 1'b1;
      repeat (3) @(posedge clk);
      chk("decel falls", 1, fout < 16'h0BB8);
      uv <= 1'b1;
      repeat (3) @(posedge clk);
      chk("decel coast", 0, on);
      uv <= 1'b0;
      bcl <= 1'b0;
      coast <= 1'b1;
      @(posedge clk);
      coast <= 1'b0;
      $display("done: decel stop");
   endtask
   task automatic t_m0;
      apb(1, 8'h00, 32'h0000_0000);
      wf(16'h0BB8, 0);
      uv <= 1'b1;
      repeat (2) @(posedge clk);
      chk("trip off", 0, on);
      chk("trip alarm", 1, alarm);
      chk("trip no restart", 0, ract);
      uv <= 1'b0;
      forward_run_terminal <= 1'b0;
      apb(1, 8'h18, 32'h0000_0003);
      apb(0, 8'h18, 0);
      chk("alarm cleared", 0, rd[1]);
      $display("done: trip now");
   endtask
   // watchdog: tests need well under this span
   initial begin
      #200000;
      fails++;
      final_report;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_limit;
      t_m4;
      t_m5;
      t_fix;
      t_m2;
      t_m0;
      final_report;
   end
endmodule
`default_nettype wire
